// file: hw/lci_pkg.sv
// Package for the contrast, static indicator and power-save command block
// Assumes a single 200 MHz clock and byte-wide command writes
package lci_pkg;
    // ---------------------------------------------------------------
    // Command codes
    // ---------------------------------------------------------------
    localparam logic [7:0] LCI_CMD_CONTRAST_MODE = 8'h81;
    localparam logic [6:0] LCI_CMD_INDICATOR = 7'h56;
    localparam logic [6:0] LCI_CMD_DISPLAY = 7'h57;
    localparam logic [6:0] LCI_CMD_ENTIRE_ON = 7'h52;
    localparam logic [7:0] LCI_CMD_SOFT_RESET = 8'hE2;

    // ---------------------------------------------------------------
    // Field positions and widths
    // ---------------------------------------------------------------
    localparam int LCI_CONTRAST_W = 6;
    localparam int LCI_BLINK_W = 2;
    localparam int LCI_FLAG_BIT = 0;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [5:0] LCI_CONTRAST_RESET = 6'h00;
    localparam logic [1:0] LCI_BLINK_RESET = 2'h0;

    // ---------------------------------------------------------------
    // Indicator modes
    // ---------------------------------------------------------------
    localparam logic [1:0] LCI_IND_OFF = 2'h0;
    localparam logic [1:0] LCI_IND_FAST = 2'h1;
    localparam logic [1:0] LCI_IND_SLOW = 2'h2;
    localparam logic [1:0] LCI_IND_STEADY = 2'h3;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int LCI_CLK_MHZ = 200;
    localparam int LCI_BLINK_FAST_MS = 500;
    localparam int LCI_BLINK_SLOW_MS = 1000;
    localparam longint LCI_FAST_CYCLES = longint'(LCI_BLINK_FAST_MS) * 1000 * LCI_CLK_MHZ;
    localparam longint LCI_SLOW_CYCLES = longint'(LCI_BLINK_SLOW_MS) * 1000 * LCI_CLK_MHZ;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [2:0]
    {
        LCI_DEC_NORMAL = 3'b001,
        LCI_DEC_CONTRAST = 3'b010,
        LCI_DEC_INDICATOR = 3'b100
    } lci_dec_t;

    typedef enum logic [2:0]
    {
        LCI_PWR_RUN = 3'b001,
        LCI_PWR_SLEEP = 3'b010,
        LCI_PWR_STANDBY = 3'b100
    } lci_pwr_t;

    typedef struct packed
    {
        logic drive_off;
        logic osc_off;
        logic supply_off;
        logic sleep;
        logic standby;
    } lci_power_t;
endpackage

// file: hw/lci_core.sv
// Command decoder for contrast, static indicator and power save
// Assumes host bus logic presents each written byte with a one-cycle strobe
// Summary of operation
// RULE1: Register-set byte loads low six bits as contrast; top two bits ignored.
// RULE2: Contrast mode ends once the register-set byte is loaded.
// RULE3: Host should program contrast 100000 when adjustment is unused.
// RULE4: Byte 1010110x: bit0 low indicator off, high on and arm register byte.
// RULE5: After indicator-on the next byte is only the indicator register byte.
// RULE6: Indicator-off is complete in one byte.
// RULE7: Indicator mode 00 off, 01 fast blink, 10 slow blink, 11 steady.
// RULE8: Indicator output responds only to indicator commands; software reset also clears the mode to off here.
// RULE9: Entire-on while display off: sleep if indicator off, else standby.
// RULE10: Sleep ends after power-save-off command plus indicator-on command.
// RULE11: Sleep halts oscillator and liquid-crystal supply.
// RULE12: Sleep and standby stop matrix drive, outputs grounded.
// RULE13: Low-power modes keep RAM, settings and host RAM access.
// RULE14: Standby stops supply and drive but keeps indicator blinking.
// RULE15: Software reset in standby moves to sleep.
// RULE16: Byte 10000001 enters contrast mode; nothing else accepted until data.
// RULE17: Byte 1010111x turns display on with bit0 high, off when low.
// RULE18: Byte 1010010x sets entire-display-on; set while off triggers power save.
// RULE19: Software reset clears contrast and indicator mode registers.
// RULE20: Blink periods come from a counter dividing the clock.
// RULE21: While awaiting a second byte, any command byte is register data.
module lci_core
    import lci_pkg::*;
#(
    parameter longint FAST_CYCLES = LCI_FAST_CYCLES,
    parameter longint SLOW_CYCLES = LCI_SLOW_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wr_strobe,
    input wire logic command_data_select,
    input wire logic [7:0] wr_data,
    output logic [5:0] contrast_level,
    output logic [1:0] indicator_blink_select,
    output logic indicator_segment_out,
    output logic display_on,
    output logic entire_on,
    output lci_power_t power_state
);
    if (FAST_CYCLES < 2 || SLOW_CYCLES < 2 || FAST_CYCLES > 64'h0000_0000_FFFF_FFFF
        || SLOW_CYCLES > 64'h0000_0000_FFFF_FFFF)
    begin
        $error("lci_core: blink counts out of range");
    end

    // ---------------------------------------------------------------
    // Command decoding state
    // ---------------------------------------------------------------
    lci_dec_t dec_q, dec_d;
    lci_pwr_t pwr_q, pwr_d;
    logic [5:0] contrast_q, contrast_d;
    logic [1:0] blink_q, blink_d;
    logic ind_on_q, ind_on_d;
    logic disp_q, disp_d;
    logic entire_q, entire_d;
    logic wake_cmd_q, wake_cmd_d;
    logic wake_ind_q, wake_ind_d;
    logic cmd;

    assign cmd = wr_strobe && !command_data_select;

    always_comb
    begin
        dec_d = dec_q;
        pwr_d = pwr_q;
        contrast_d = contrast_q;
        blink_d = blink_q;
        ind_on_d = ind_on_q;
        disp_d = disp_q;
        entire_d = entire_q;
        wake_cmd_d = wake_cmd_q;
        wake_ind_d = wake_ind_q;
        if (cmd)
        begin
            case (dec_q)
                LCI_DEC_CONTRAST:
                begin
                    contrast_d = wr_data[LCI_CONTRAST_W-1:0]; // RULE1 RULE21
                    dec_d = LCI_DEC_NORMAL; // RULE2
                end
                LCI_DEC_INDICATOR:
                begin
                    blink_d = wr_data[LCI_BLINK_W-1:0]; // RULE7 RULE21
                    dec_d = LCI_DEC_NORMAL; // RULE5
                end
                LCI_DEC_NORMAL:
                begin
                    if (wr_data == LCI_CMD_CONTRAST_MODE)
                        dec_d = LCI_DEC_CONTRAST; // RULE16
                    else if (wr_data[7:1] == LCI_CMD_INDICATOR)
                    begin
                        ind_on_d = wr_data[LCI_FLAG_BIT]; // RULE4 RULE8
                        if (wr_data[LCI_FLAG_BIT])
                        begin
                            dec_d = LCI_DEC_INDICATOR; // RULE4
                            wake_ind_d = 1'b1;
                        end
                        // Off variant leaves decoding normal RULE6
                    end
                    else if (wr_data[7:1] == LCI_CMD_DISPLAY)
                    begin
                        disp_d = wr_data[LCI_FLAG_BIT]; // RULE17
                        if (wr_data[LCI_FLAG_BIT])
                            wake_cmd_d = 1'b1; // RULE10
                    end
                    else if (wr_data[7:1] == LCI_CMD_ENTIRE_ON)
                    begin
                        entire_d = wr_data[LCI_FLAG_BIT]; // RULE18
                        if (!wr_data[LCI_FLAG_BIT])
                            wake_cmd_d = 1'b1; // RULE10
                        else if (!disp_q && pwr_q == LCI_PWR_RUN)
                        begin
                            pwr_d = ind_on_q ? LCI_PWR_STANDBY : LCI_PWR_SLEEP; // RULE9
                            wake_cmd_d = 1'b0;
                            wake_ind_d = 1'b0;
                        end
                    end
                    else if (wr_data == LCI_CMD_SOFT_RESET)
                    begin
                        contrast_d = LCI_CONTRAST_RESET; // RULE19
                        blink_d = LCI_BLINK_RESET; // RULE19
                        if (pwr_q == LCI_PWR_STANDBY)
                        begin
                            pwr_d = LCI_PWR_SLEEP; // RULE15
                            wake_cmd_d = 1'b0;
                            wake_ind_d = 1'b0;
                        end
                    end
                end
                default: dec_d = LCI_DEC_NORMAL;
            endcase
        end
        // Leaving a low-power mode
        if (pwr_q == LCI_PWR_SLEEP && wake_cmd_d && wake_ind_d)
        begin
            pwr_d = LCI_PWR_RUN; // RULE10
            wake_cmd_d = 1'b0;
            wake_ind_d = 1'b0;
        end
        else if (pwr_q == LCI_PWR_STANDBY && wake_cmd_d)
        begin
            pwr_d = LCI_PWR_RUN;
            wake_cmd_d = 1'b0;
            wake_ind_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            dec_q <= LCI_DEC_NORMAL;
            pwr_q <= LCI_PWR_RUN;
            contrast_q <= LCI_CONTRAST_RESET;
            blink_q <= LCI_BLINK_RESET;
            ind_on_q <= 1'b0;
            disp_q <= 1'b0;
            entire_q <= 1'b0;
            wake_cmd_q <= 1'b0;
            wake_ind_q <= 1'b0;
        end
        else
        begin
            dec_q <= dec_d;
            pwr_q <= pwr_d;
            contrast_q <= contrast_d;
            blink_q <= blink_d;
            ind_on_q <= ind_on_d;
            disp_q <= disp_d;
            entire_q <= entire_d;
            wake_cmd_q <= wake_cmd_d;
            wake_ind_q <= wake_ind_d;
        end
    end

    // ---------------------------------------------------------------
    // Blink divider and indicator drive
    // ---------------------------------------------------------------
    logic [31:0] div_q, div_d;
    logic phase_q, phase_d;
    logic seg_q, seg_d;
    logic [31:0] period;
    logic osc_run;

    assign osc_run = (pwr_q != LCI_PWR_SLEEP); // RULE11
    assign period = (blink_q == LCI_IND_SLOW) ? 32'(SLOW_CYCLES) : 32'(FAST_CYCLES);

    always_comb
    begin
        div_d = div_q;
        phase_d = phase_q;
        if (!osc_run || blink_q == LCI_IND_OFF || blink_q == LCI_IND_STEADY)
        begin
            div_d = 32'h0000_0000;
            phase_d = 1'b1;
        end
        else if (div_q >= period - 32'h0000_0001)
        begin
            div_d = 32'h0000_0000;
            phase_d = !phase_q; // RULE20
        end
        else
            div_d = div_q + 32'h0000_0001; // RULE20
        case (blink_q)
            LCI_IND_OFF: seg_d = 1'b0;
            LCI_IND_STEADY: seg_d = ind_on_q;
            default: seg_d = ind_on_q && phase_q; // RULE7 RULE14
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            div_q <= 32'h0000_0000;
            phase_q <= 1'b1;
            seg_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            phase_q <= phase_d;
            seg_q <= seg_d;
        end
    end

    // ---------------------------------------------------------------
    // Registered outputs
    // ---------------------------------------------------------------
    lci_power_t pw_q, pw_d;

    always_comb
    begin
        pw_d.sleep = (pwr_d == LCI_PWR_SLEEP);
        pw_d.standby = (pwr_d == LCI_PWR_STANDBY);
        pw_d.osc_off = (pwr_d == LCI_PWR_SLEEP); // RULE11
        pw_d.supply_off = (pwr_d != LCI_PWR_RUN); // RULE11 RULE14
        pw_d.drive_off = (pwr_d != LCI_PWR_RUN); // RULE12 RULE13
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            pw_q <= '0;
        else
            pw_q <= pw_d;
    end

    assign contrast_level = contrast_q;
    assign indicator_blink_select = blink_q;
    assign indicator_segment_out = seg_q;
    assign display_on = disp_q;
    assign entire_on = entire_q;
    assign power_state = pw_q;
endmodule

// file: bench/lci_core_assertions.sv
// Checker for the contrast, indicator and power-save command block
// Sees only lci_core ports; bound from the bench top
module lci_core_assertions
    import lci_pkg::*;
#(
    parameter longint FAST_CYCLES = 4,
    parameter longint SLOW_CYCLES = 8
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wr_strobe,
    input wire logic command_data_select,
    input wire logic [7:0] wr_data,
    input wire logic [5:0] contrast_level,
    input wire logic [1:0] indicator_blink_select,
    input wire logic indicator_segment_out,
    input wire logic display_on,
    input wire logic entire_on,
    input wire lci_power_t power_state
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // Second-byte and indicator-on tracking
    // ---------------------------------------------------------------
    logic take, norm, pend_q, pend_d, ind_q, ind_d;
    assign take = wr_strobe && !command_data_select;
    assign norm = take && !pend_q;
    always_comb
    begin
        pend_d = take ? norm && (wr_data == 8'h81 || wr_data == 8'hAD) : pend_q;
        ind_d = (norm && wr_data[7:1] == LCI_CMD_INDICATOR) ? wr_data[0] : ind_q;
    end
    always_ff @(posedge ref_clk)
    begin
        pend_q <= rst_n ? pend_d : 1'b0;
        ind_q <= rst_n ? ind_d : 1'b0;
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    chk_contrast_load: assert property (
        norm && wr_data == 8'h81 ##1 take |=> contrast_level == $past(wr_data[5:0]))
        else $error("contrast not loaded");
    chk_mode_load: assert property (
        norm && wr_data == 8'hAD ##1 take |=> indicator_blink_select == $past(wr_data[1:0]))
        else $error("indicator mode not loaded");
    chk_settings_hold: assert property (!$past(take) |-> $stable(contrast_level))
        else $error("contrast changed without a command");
    chk_display_cmd: assert property (
        norm && wr_data[7:1] == LCI_CMD_DISPLAY |=> display_on == $past(wr_data[0]))
        else $error("display state wrong");
    chk_entire_cmd: assert property (
        norm && wr_data[7:1] == LCI_CMD_ENTIRE_ON |=> entire_on == $past(wr_data[0]))
        else $error("entire-on state wrong");
    chk_power_entry: assert property (
        norm && wr_data == 8'hA5 && !display_on && !power_state.sleep && !power_state.standby
        |=> power_state.sleep == !ind_q && power_state.standby == ind_q)
        else $error("power-save entry wrong");
    chk_sleep_outputs: assert property (
        power_state.sleep |-> power_state.osc_off && power_state.supply_off && power_state.drive_off)
        else $error("sleep left something running");
    chk_standby_outputs: assert property (
        power_state.standby |-> power_state.supply_off && power_state.drive_off && !power_state.osc_off)
        else $error("standby outputs wrong");
    chk_reset_sleep: assert property (
        norm && wr_data == 8'hE2 && power_state.standby |=> power_state.sleep)
        else $error("reset in standby did not sleep");
    chk_indicator_off: assert property (
        $past(indicator_blink_select) == LCI_IND_OFF |-> !indicator_segment_out)
        else $error("indicator lit while off");
    chk_indicator_steady: assert property (
        $past(indicator_blink_select) == LCI_IND_STEADY |-> indicator_segment_out == $past(ind_q))
        else $error("steady indicator wrong");
    cover property (power_state.sleep);
    cover property (power_state.standby);
    cover property (norm && wr_data == 8'h81 ##1 take);
endmodule

// file: bench/lci_host_model.sv
// Host model writing command and data bytes
// Caller starts each write just after a rising edge
module lci_host_model
(
    input wire logic ref_clk,
    output logic wr_strobe,
    output logic command_data_select,
    output logic [7:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        wr_strobe = 1'b0;
        command_data_select = 1'b0;
        wr_data = 8'h00;
    end
    // One byte per edge; strobe stays high across back-to-back bytes
    task automatic put(input logic sel, input logic [7:0] b);
        wr_strobe <= 1'b1;
        command_data_select <= sel;
        wr_data <= b;
        @(posedge ref_clk);
    endtask
    // Released bus shows a changing pattern
    task automatic idle();
        wr_strobe <= 1'b0;
        wr_data <= ~wr_data;
        @(posedge ref_clk);
    endtask
endmodule

// file: bench/tb.sv
// Bench top for lci_core: directed command sequences
// Blink counts shortened to 4 and 8 cycles
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst_n, wr_strobe, command_data_select, seg, last;
    logic [7:0] wr_data;
    logic [5:0] contrast_level;
    logic [1:0] indicator_blink_select;
    logic display_on, entire_on;
    lci_pkg::lci_power_t power_state;
    int fails = 0;
    int n_compared = 0;
    int flips;
    lci_core #(.FAST_CYCLES(4), .SLOW_CYCLES(8)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .wr_strobe(wr_strobe), .command_data_select(command_data_select), .wr_data(wr_data),
        .contrast_level(contrast_level), .indicator_blink_select(indicator_blink_select),
        .indicator_segment_out(seg), .display_on(display_on), .entire_on(entire_on),
        .power_state(power_state));
    lci_host_model u_host (.ref_clk(ref_clk), .wr_strobe(wr_strobe),
        .command_data_select(command_data_select), .wr_data(wr_data));
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (3) u_host.idle();
    endtask
    task automatic give_verdict();
        $display("compared %0d, fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic sc_contrast();
        u_host.put(1'b0, 8'h81);
        u_host.put(1'b0, 8'hE0);
        u_host.put(1'b1, 8'h3F);
        settle();
        chk(8'(contrast_level), 8'h20);
        u_host.put(1'b0, 8'h81);
        u_host.put(1'b0, 8'hAF);
        settle();
        chk(8'(contrast_level), 8'h2F);
        chk(8'(display_on), 8'h00);
        u_host.put(1'b0, 8'hAF);
        settle();
        chk(8'(display_on), 8'h01);
    endtask
    task automatic sc_indicator();
        for (int m = 0; m < 4; m++)
        begin
            u_host.put(1'b0, 8'hAD);
            u_host.put(1'b0, 8'hFC | 8'(m));
            settle();
            chk(8'(indicator_blink_select), 8'(m));
            flips = 0;
            last = seg;
            repeat (16)
            begin
                u_host.idle();
                flips += int'(seg != last);
                last = seg;
            end
            chk(8'(flips), (m == 1) ? 8'h04 : (m == 2) ? 8'h02 : 8'h00);
            if (m != 1 && m != 2)
                chk(8'(seg), 8'(m != 0));
        end
        u_host.put(1'b0, 8'hAE);
        u_host.put(1'b0, 8'hA6);
        settle();
        chk(8'(seg), 8'h01);
    endtask
    task automatic sc_power();
        u_host.put(1'b0, 8'hA5);
        settle();
        chk(8'(power_state), 8'h15);
        chk(8'(seg), 8'h01);
        chk(8'(contrast_level), 8'h2F);
        u_host.put(1'b0, 8'hE2);
        settle();
        chk(8'(power_state), 8'h1E);
        chk(8'({contrast_level, indicator_blink_select}), 8'h00);
        u_host.put(1'b0, 8'hA4);
        settle();
        chk(8'(power_state[1:0]), 8'h02);
        u_host.put(1'b0, 8'hAD);
        u_host.put(1'b0, 8'h03);
        settle();
        chk(8'({entire_on, power_state[1:0]}), 8'h00);
        u_host.put(1'b0, 8'hAC);
        u_host.put(1'b0, 8'hA5);
        settle();
        chk(8'({seg, power_state}), 8'h1E);
        u_host.put(1'b0, 8'hAD);
        u_host.put(1'b0, 8'h01);
        settle();
        chk(8'(power_state[1:0]), 8'h02);
        u_host.put(1'b0, 8'hAF);
        settle();
        chk(8'(power_state[1:0]), 8'h00);
        u_host.put(1'b0, 8'hAE);
        u_host.put(1'b0, 8'hA5);
        settle();
        chk(8'(power_state), 8'h15);
        u_host.put(1'b0, 8'hA4);
        settle();
        chk(8'({entire_on, power_state}), 8'h00);
        u_host.put(1'b0, 8'hAF);
        u_host.put(1'b0, 8'hA5);
        settle();
        chk(8'({entire_on, power_state}), 8'h20);
    endtask
    initial
    begin
        rst_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        sc_contrast();
        sc_indicator();
        sc_power();
        give_verdict();
    end
    initial
    begin
        #100000;
        fails++;
        give_verdict();
    end
endmodule
bind lci_core lci_core_assertions #(.FAST_CYCLES(FAST_CYCLES), .SLOW_CYCLES(SLOW_CYCLES)) u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .wr_strobe(wr_strobe),
    .command_data_select(command_data_select), .wr_data(wr_data),
    .contrast_level(contrast_level), .indicator_blink_select(indicator_blink_select),
    .indicator_segment_out(indicator_segment_out), .display_on(display_on),
    .entire_on(entire_on), .power_state(power_state));
